// ---- rtl/fpecr_regs.sv ----
// fpecr_regs: flash program/erase control registers behind AHB-Lite.
// assumes one master, single word transfers, mode pins synchronous.
//
// Behaviour
// RL1 - flash registers accessible only with high voltage
// RL2 - no voltage: mode 2 external, mode 3 ones
// RL3 - mode 1: writes ignored, reads all ones
// RL4 - modes 2 and 3 start from zero
// RL5 - mode control cleared: reset, standby, no voltage
// RL6 - reset with voltage present reads 0x80
// RL7 - bit 7 is read-only voltage flag
// RL8 - bits 6 to 4 read zero
// RL9 - bit 3 selects erase-verify mode
// RL10 - bit 2 selects program-verify mode
// RL11 - bit 1 starts erase mode
// RL12 - bit 0 starts program mode
// RL13 - software sets at most one operation bit
// RL14 - software arms watchdog before program or erase
// RL15 - large select bits enable large blocks
// RL16 - small select bits enable small blocks
// RL17 - block selects cleared: reset, standby, no voltage
// RL18 - mode 2: large select top bit unwritable
// RL19 - single overlay bit blocks program and erase
// RL20 - high-voltage detect synchronised before use
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module fpecr_regs
    import fpecr_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int SYNC_STAGES = FPECR_SYNC_STAGES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic hv_program_pin,
    input wire logic mode_pin_high,
    input wire logic mode_pin_low,
    input wire logic standby,
    output logic program_mode,
    output logic erase_mode,
    output logic program_verify_mode,
    output logic erase_verify_mode,
    output logic [7:0] large_block_bits,
    output logic [7:0] small_block_bits,
    output logic [7:0] wait_overlay_bits,
    output logic ext_space_hit
);

    // the decode checks bits above the register window, so at least one must exist
    if (ADDR_W < 19) begin : g_bad_addr_w
        $error("fpecr_regs needs at least 19 address bits");
    end

    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("fpecr_regs needs at least two synchroniser stages");
    end

    // ==========================================================
    // address decode
    function automatic fpecr_sel_t decode(input logic [ADDR_W-1:0] a);
        logic [15:0] idx;
        idx = a[17:2];
        if (a[ADDR_W-1:18] != '0) begin
            decode = FPECR_SEL_NONE;
        end else if (idx == FPECR_IDX_FMC) begin
            decode = FPECR_SEL_FMC;
        end else if (idx == FPECR_IDX_LBS) begin
            decode = FPECR_SEL_LBS;
        end else if (idx == FPECR_IDX_SBS) begin
            decode = FPECR_SEL_SBS;
        end else if (idx == FPECR_IDX_WOC) begin
            decode = FPECR_SEL_WOC;
        end else begin
            decode = FPECR_SEL_NONE;
        end
    endfunction

    function automatic logic is_flash(input fpecr_sel_t sel);
        is_flash = (sel == FPECR_SEL_FMC) || (sel == FPECR_SEL_LBS) ||
            (sel == FPECR_SEL_SBS);
    endfunction

    // ==========================================================
    // high-voltage detect
    logic hv;

    // raw pin may move at any time relative to clk
    fpecr_sync #(
        .STAGES(SYNC_STAGES)
    ) u_hv_sync ( // RL20
        .clk(clk),
        .rst(rst),
        .din(hv_program_pin),
        .dout(hv)
    );

    // ==========================================================
    // state
    fpecr_state_t s;
    fpecr_state_t next_s;

    logic flash_en;
    logic mode2;
    logic acc_ok;
    logic take;
    logic protect;
    fpecr_sel_t asel;
    logic [7:0] wd;

    always_comb begin
        next_s = s;
        // mode 0 is illegal and handled like mode 1
        flash_en = mode_pin_high;
        mode2 = mode_pin_high & ~mode_pin_low;
        acc_ok = flash_en & hv; // RL1
        wd = hwdata[7:0];
        take = hsel & hready & htrans[1];
        asel = take ? decode(haddr) : FPECR_SEL_NONE;

        // data phase write
        if (s.dp_valid && s.dp_write) begin
            if (s.dp_sel == FPECR_SEL_WOC) begin
                next_s.woc = wd;
            end else if (acc_ok) begin // RL1
                unique case (s.dp_sel)
                    FPECR_SEL_FMC: begin
                        next_s.fmc = wd[3:0]; // RL9 RL10 RL11 RL12
                    end
                    FPECR_SEL_LBS: begin
                        next_s.lbs = wd; // RL15
                        if (mode2) begin
                            next_s.lbs[FPECR_LBS_TOP] = s.lbs[FPECR_LBS_TOP]; // RL18
                        end
                    end
                    FPECR_SEL_SBS: begin
                        next_s.sbs = wd; // RL16
                    end
                    FPECR_SEL_NONE, FPECR_SEL_WOC: begin
                    end
                endcase
            end
        end

        // clearing overrides any mode control or block select write in the same cycle
        if (standby || !hv || !flash_en) begin
            next_s.fmc = FPECR_FMC_RST[3:0]; // RL5 RL3
            next_s.lbs = FPECR_LBS_RST; // RL17
            next_s.sbs = FPECR_SBS_RST; // RL17
        end

        // half-set overlay keeps program and erase off, verify stays usable
        protect = next_s.woc[FPECR_WOC_OVH] ^ next_s.woc[FPECR_WOC_OVL]; // RL19
        next_s.ops[3] = next_s.fmc[FPECR_FMC_ERVF]; // RL9
        next_s.ops[2] = next_s.fmc[FPECR_FMC_PGVF]; // RL10
        next_s.ops[1] = next_s.fmc[FPECR_FMC_ER] & ~protect; // RL11 RL19
        next_s.ops[0] = next_s.fmc[FPECR_FMC_PG] & ~protect; // RL12 RL19

        // address phase capture
        next_s.dp_valid = take;
        next_s.dp_write = take & hwrite;
        next_s.dp_sel = asel;
        next_s.ext_hit = is_flash(asel) & mode2 & ~hv; // RL2

        // read data from next values so back-to-back read sees the write
        next_s.rdata = FPECR_ZERO;
        if (take && !hwrite) begin
            if (asel == FPECR_SEL_WOC) begin
                next_s.rdata = next_s.woc;
            end else if (is_flash(asel)) begin
                if (!flash_en) begin
                    next_s.rdata = FPECR_ONES; // RL3
                end else if (!hv) begin
                    next_s.rdata = mode2 ? FPECR_ZERO : FPECR_ONES; // RL2
                end else begin
                    unique case (asel)
                        FPECR_SEL_FMC: begin
                            // flag tracks the detect, bits 6..4 tied low
                            next_s.rdata = {hv, 3'h0, next_s.fmc}; // RL7 RL6 RL8
                        end
                        FPECR_SEL_LBS: begin
                            next_s.rdata = next_s.lbs;
                        end
                        FPECR_SEL_SBS: begin
                            next_s.rdata = next_s.sbs;
                        end
                        FPECR_SEL_NONE, FPECR_SEL_WOC: begin
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= FPECR_STATE_RST; // RL4 RL5 RL17
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = {24'h000000, s.rdata};
    assign erase_verify_mode = s.ops[3];
    assign program_verify_mode = s.ops[2];
    assign erase_mode = s.ops[1];
    assign program_mode = s.ops[0];
    assign large_block_bits = s.lbs;
    assign small_block_bits = s.sbs;
    assign wait_overlay_bits = s.woc;
    assign ext_space_hit = s.ext_hit;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence seq_rd_flash;
        take && !hwrite && is_flash(decode(haddr));
    endsequence

    sequence seq_fmc_wr_ok;
        s.dp_valid && s.dp_write && s.dp_sel == FPECR_SEL_FMC && acc_ok && !standby;
    endsequence

    sequence seq_lbs_wr_m2;
        s.dp_valid && s.dp_write && s.dp_sel == FPECR_SEL_LBS && mode2;
    endsequence

    sequence seq_lbs_wr_ok;
        s.dp_valid && s.dp_write && s.dp_sel == FPECR_SEL_LBS && acc_ok && !standby;
    endsequence

    sequence seq_flash_wr;
        s.dp_valid && s.dp_write && is_flash(s.dp_sel);
    endsequence

    AST_SBS_WRITE: assert property ( // RL1
        s.dp_valid && s.dp_write && s.dp_sel == FPECR_SEL_SBS && acc_ok && !standby
        |=> s.sbs == $past(hwdata[7:0]))
        else $error("small select write with voltage not stored");

    AST_MODE3_ONES: assert property ( // RL2
        seq_rd_flash and (mode_pin_high && mode_pin_low && !hv)
        |=> hrdata[7:0] == FPECR_ONES && !ext_space_hit)
        else $error("mode 3 read without voltage not all ones");

    AST_MODE2_EXT: assert property ( // RL2
        seq_rd_flash and (mode2 && !hv) |=> ext_space_hit && hrdata[7:0] == FPECR_ZERO)
        else $error("mode 2 access without voltage not external");

    AST_MODE1_ONES: assert property ( // RL3
        seq_rd_flash and !mode_pin_high |=> hrdata[7:0] == FPECR_ONES)
        else $error("mode 1 read not all ones");

    AST_CLEAR: assert property ( // RL5
        (!hv || standby) |=> s.fmc == 4'h0 && s.lbs == 8'h00 && s.sbs == 8'h00
        ##1 (!program_mode || hv))
        else $error("control not cleared without voltage or in standby");

    AST_FMC_READ: assert property ( // RL7
        seq_rd_flash and (decode(haddr) == FPECR_SEL_FMC && acc_ok)
        |=> hrdata[7] == $past(hv) && hrdata[6:4] == 3'h0)
        else $error("mode control read flag or reserved bits wrong");

    AST_RESET_ZERO: assert property ( // RL4
        $past(rst) |-> s.fmc == 4'h0 && s.lbs == 8'h00 && s.sbs == 8'h00 && !erase_mode)
        else $error("registers not zero after reset");

    AST_OP_WRITE: assert property ( // RL12
        seq_fmc_wr_ok and !protect
        |=> {erase_verify_mode, program_verify_mode, erase_mode, program_mode} == $past(hwdata[3:0]))
        else $error("operation outputs do not follow written bits");

    AST_LB_TOP: assert property ( // RL18
        seq_lbs_wr_m2 and !s.lbs[FPECR_LBS_TOP] |=> !large_block_bits[7])
        else $error("large select top bit written in mode 2");

    AST_PROTECT: assert property ( // RL19
        (s.woc[FPECR_WOC_OVH] != s.woc[FPECR_WOC_OVL]) |-> !program_mode && !erase_mode)
        else $error("program or erase active while overlay half set");

    AST_LBS_WRITE: assert property ( // RL15
        seq_lbs_wr_ok and !mode2
        |=> large_block_bits == $past(hwdata[7:0]))
        else $error("large select write with voltage not stored");

    AST_LBS_LOW_M2: assert property ( // RL18
        seq_lbs_wr_ok and mode2
        |=> large_block_bits[6:0] == $past(hwdata[6:0]))
        else $error("large select low bits not written in mode 2");

    AST_VERIFY_WRITE: assert property ( // RL9 RL10
        seq_fmc_wr_ok
        |=> erase_verify_mode == $past(hwdata[FPECR_FMC_ERVF])
            && program_verify_mode == $past(hwdata[FPECR_FMC_PGVF]))
        else $error("verify outputs do not follow written bits");

    AST_PE_BLOCKED: assert property ( // RL19
        seq_fmc_wr_ok and protect
        |=> !program_mode && !erase_mode && s.fmc == $past(hwdata[3:0]))
        else $error("program or erase entered while overlay half set");

    AST_MODE1_NO_WRITE: assert property ( // RL3
        seq_flash_wr and !mode_pin_high
        |=> s.fmc == 4'h0 && s.lbs == 8'h00 && s.sbs == 8'h00)
        else $error("flash register written in mode 1");

    AST_NOHV_NO_WRITE: assert property ( // RL2
        seq_flash_wr and !hv
        |=> s.fmc == 4'h0 && s.lbs == 8'h00 && s.sbs == 8'h00)
        else $error("flash register written without voltage");

    AST_STANDBY_CLEAR: assert property ( // RL5 RL17
        standby
        |=> {program_mode, erase_mode, program_verify_mode, erase_verify_mode} == 4'h0
            && large_block_bits == 8'h00 && small_block_bits == 8'h00)
        else $error("standby did not clear mode and block outputs");

    AST_HV_SYNC: assert property ( // RL20
        !$past(rst) && !$past(rst, SYNC_STAGES)
        |-> hv == $past(hv_program_pin, SYNC_STAGES))
        else $error("voltage detect not delayed by the synchroniser");

    AST_WOC_WRITE: assert property ( // RL19
        s.dp_valid && s.dp_write && s.dp_sel == FPECR_SEL_WOC
        |=> wait_overlay_bits == $past(hwdata[7:0]))
        else $error("overlay control write not stored");

    AST_RDATA_IDLE: assert property ( // RL1
        !(take && !hwrite) |=> hrdata == 32'h00000000)
        else $error("read data not zero outside a read data phase");

endmodule // fpecr_regs

// ---- common/fpecr_pkg.sv ----
// fpecr_pkg: offsets, reset values, field positions and state layout
// for the flash program/erase control register set.
// assumes register indices are word indices on an AHB-Lite bus.
package fpecr_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [15:0] FPECR_IDX_FMC = 16'hff80;
    localparam logic [15:0] FPECR_IDX_LBS = 16'hff82;
    localparam logic [15:0] FPECR_IDX_SBS = 16'hff83;
    localparam logic [15:0] FPECR_IDX_WOC = 16'hffc2;

    // ==========================================================
    // values after reset and fixed read values
    localparam logic [7:0] FPECR_FMC_RST = 8'h00;
    localparam logic [7:0] FPECR_LBS_RST = 8'h00;
    localparam logic [7:0] FPECR_SBS_RST = 8'h00;
    localparam logic [7:0] FPECR_WOC_RST = 8'h08;
    localparam logic [7:0] FPECR_ONES = 8'hff;
    localparam logic [7:0] FPECR_ZERO = 8'h00;

    // ==========================================================
    // field positions
    localparam int FPECR_FMC_HV = 7;
    localparam int FPECR_FMC_ERVF = 3;
    localparam int FPECR_FMC_PGVF = 2;
    localparam int FPECR_FMC_ER = 1;
    localparam int FPECR_FMC_PG = 0;
    localparam int FPECR_LBS_TOP = 7;
    localparam int FPECR_WOC_OVH = 7;
    localparam int FPECR_WOC_OVL = 6;

    // ==========================================================
    // timing
    localparam int FPECR_SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        FPECR_SEL_NONE,
        FPECR_SEL_FMC,
        FPECR_SEL_LBS,
        FPECR_SEL_SBS,
        FPECR_SEL_WOC
    } fpecr_sel_t;

    typedef struct packed {
        logic dp_valid;
        logic dp_write;
        fpecr_sel_t dp_sel;
        logic [3:0] fmc;
        logic [7:0] lbs;
        logic [7:0] sbs;
        logic [7:0] woc;
        logic [3:0] ops;
        logic [7:0] rdata;
        logic ext_hit;
    } fpecr_state_t;

    localparam fpecr_state_t FPECR_STATE_RST = '{
        dp_valid: 1'b0,
        dp_write: 1'b0,
        dp_sel: FPECR_SEL_NONE,
        fmc: FPECR_FMC_RST[3:0],
        lbs: FPECR_LBS_RST,
        sbs: FPECR_SBS_RST,
        woc: FPECR_WOC_RST,
        ops: 4'h0,
        rdata: FPECR_ZERO,
        ext_hit: 1'b0
    };

endpackage

// ---- rtl/fpecr_sync.sv ----
// fpecr_sync: multi-stage level synchroniser.
// assumes the input is a slow level with no timing relation to clk.
`timescale 1ns/10ps
module fpecr_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);

    logic [STAGES-1:0] chain;

    if (STAGES < 2) begin : g_bad_stages
        $error("fpecr_sync needs at least two stages");
    end

    // only the last stage is looked at outside this module
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chain <= '0;
        end else begin
            chain <= {chain[STAGES-2:0], din};
        end
    end

    assign dout = chain[STAGES-1];

endmodule // fpecr_sync

// ---- dv/fpecr_regs_tb.sv ----
// fpecr_regs_tb: self-checking bench for the flash control registers.
// assumes a zero-wait AHB-Lite slave and a two-flop voltage synchroniser.
`timescale 1ns/10ps
module fpecr_regs_tb
    import fpecr_pkg::*;
;
    logic clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic hv, mph, mpl, stby, pm, em, pvm, evm, ext;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] lbb, sbb, wob;
    logic [31:0] seed;
    int n_errors, cmp_count, m_fmc, m_lbs, m_sbs, m_woc, m_mode;
    bit m_hv;
    int fi[3] = '{FPECR_IDX_FMC, FPECR_IDX_LBS, FPECR_IDX_SBS};
    int ov[3] = '{8'h40, 8'h80, 8'hc0};

    assign hready = hreadyout;

    fpecr_regs #(.ADDR_W(32), .SYNC_STAGES(2)) i_dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .hv_program_pin(hv), .mode_pin_high(mph), .mode_pin_low(mpl), .standby(stby),
        .program_mode(pm), .erase_mode(em), .program_verify_mode(pvm),
        .erase_verify_mode(evm), .large_block_bits(lbb), .small_block_bits(sbb),
        .wait_overlay_bits(wob), .ext_space_hit(ext)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // reference model
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic bit fl(int idx);
        return idx == FPECR_IDX_FMC || idx == FPECR_IDX_LBS || idx == FPECR_IDX_SBS;
    endfunction

    function automatic int exp_rd(int idx);
        if (idx == FPECR_IDX_WOC) return m_woc;
        if (!fl(idx)) return 0;
        if (m_mode < 2 || (!m_hv && m_mode == 3)) return 8'hff;
        if (!m_hv) return 0;
        if (idx == FPECR_IDX_FMC) return 8'h80 | m_fmc;
        return idx == FPECR_IDX_LBS ? m_lbs : m_sbs;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // bus master: waits on hready, never assumes a latency
    task automatic acc(input int idx, input bit w, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= idx * 4;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        if (!w) chk(hrdata, exp_rd(idx));
        chk(ext, fl(idx) && m_mode == 2 && !m_hv);
        chk(hresp, 1'b0);
        if (w && idx == FPECR_IDX_WOC) m_woc = wd[7:0];
        else if (w && fl(idx) && m_mode >= 2 && m_hv) begin
            if (idx == FPECR_IDX_FMC) m_fmc = wd[3:0];
            if (idx == FPECR_IDX_LBS) m_lbs = m_mode == 2 ? {m_lbs[7], wd[6:0]} : wd[7:0];
            if (idx == FPECR_IDX_SBS) m_sbs = wd[7:0];
        end
    endtask

    // pins settle through the synchroniser before the model follows
    task automatic pins(input bit h, input int md, input bit sb);
        @(posedge clk);
        hv <= h;
        mph <= md[1];
        mpl <= md[0];
        stby <= sb;
        repeat (4) @(posedge clk);
        m_hv = h;
        m_mode = md == 0 ? 1 : md;
        if (!h || m_mode < 2 || sb) begin
            m_fmc = 0;
            m_lbs = 0;
            m_sbs = 0;
        end
    endtask

    task automatic outs();
        logic ok;
        ok = ~(m_woc[7] ^ m_woc[6]);
        @(negedge clk);
        chk({pm, em, pvm, evm}, {m_fmc[0] & ok, m_fmc[1] & ok, m_fmc[2], m_fmc[3]});
        chk({lbb, sbb, wob}, {m_lbs[7:0], m_sbs[7:0], m_woc[7:0]});
    endtask

    task automatic results();
        $display("compares=%0d errors=%0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = '0;
        hv = 1'b0;
        mph = 1'b1;
        mpl = 1'b1;
        stby = 1'b0;
        seed = 32'hd2933e69;
        m_hv = 0;
        m_mode = 3;
        m_fmc = 0;
        m_lbs = 0;
        m_sbs = 0;
        m_woc = 8'h08;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        outs();
        acc(FPECR_IDX_WOC, 0, 0);
        acc(FPECR_IDX_FMC, 1, 8'h01);
        acc(FPECR_IDX_FMC, 0, 0);
        pins(0, 2, 0);
        acc(FPECR_IDX_FMC, 0, 0);
        acc(FPECR_IDX_SBS, 1, 8'h05);
        pins(1, 1, 0);
        foreach (fi[i]) acc(fi[i], 1, 8'h11);
        foreach (fi[i]) acc(fi[i], 0, 0);
        pins(1, 3, 0);
        foreach (fi[i]) acc(fi[i], 0, 0);
        for (int b = 0; b < 4; b++) begin
            acc(FPECR_IDX_FMC, 1, 8'hf0 | (1 << b));
            acc(FPECR_IDX_FMC, 0, 0);
            outs();
        end
        acc(FPECR_IDX_FMC, 1, 8'h00);
        outs();
        repeat (4) begin
            acc(FPECR_IDX_LBS, 1, rnd());
            acc(FPECR_IDX_SBS, 1, rnd());
            acc(FPECR_IDX_LBS, 0, 0);
            acc(FPECR_IDX_SBS, 0, 0);
            outs();
        end
        foreach (ov[i]) begin
            acc(FPECR_IDX_WOC, 1, ov[i]);
            acc(FPECR_IDX_FMC, 1, 8'h01);
            outs();
            acc(FPECR_IDX_FMC, 1, 8'h02);
            acc(FPECR_IDX_FMC, 0, 0);
            outs();
        end
        acc(FPECR_IDX_WOC, 1, 8'h08);
        acc(FPECR_IDX_LBS, 1, 8'h3c);
        acc(FPECR_IDX_FMC, 1, 8'h04);
        pins(1, 3, 1);
        pins(1, 3, 0);
        acc(FPECR_IDX_FMC, 0, 0);
        outs();
        acc(FPECR_IDX_SBS, 1, 8'h5a);
        acc(FPECR_IDX_FMC, 1, 8'h08);
        pins(0, 3, 0);
        outs();
        pins(1, 3, 0);
        foreach (fi[i]) acc(fi[i], 0, 0);
        pins(1, 2, 0);
        acc(FPECR_IDX_LBS, 1, 8'hff);
        acc(FPECR_IDX_LBS, 0, 0);
        outs();
        // mid-run reset with voltage present: flag comes back once the detect resyncs
        acc(FPECR_IDX_WOC, 1, 8'h3c);
        acc(FPECR_IDX_FMC, 1, 8'h04);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        m_fmc = 0;
        m_lbs = 0;
        m_sbs = 0;
        m_woc = 8'h08;
        repeat (3) @(posedge clk);
        outs();
        acc(FPECR_IDX_FMC, 0, 0);
        pins(1, 0, 0);
        acc(FPECR_IDX_SBS, 0, 0);
        acc(16'hff81, 1, 8'h55);
        acc(16'hff81, 0, 0);
        acc(16'hff84, 0, 0);
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule // fpecr_regs_tb
